/* File: move_ret_cfg.svh */
// constants for the move and return execution block
// assumes a 14-bit instruction word and a 13-bit program counter
`ifndef MOVE_RET_CFG_SVH
`define MOVE_RET_CFG_SVH
`define OPC_STORE_VAL 14'h0080
`define OPC_STORE_MSK 14'h3f80
`define OPC_LOADLIT_VAL 14'h3000
`define OPC_LOADLIT_MSK 14'h3c00
`define OPC_RETLIT_VAL 14'h3400
`define OPC_RETLIT_MSK 14'h3c00
`define OPC_NOP_VAL 14'h0000
`define OPC_NOP_MSK 14'h3f9f
`define OPC_RETURN_VAL 14'h0008
`define OPC_RETIRQ_VAL 14'h0009
`define OPC_FULL_MSK 14'h3fff
`define LIT_MSB 7
`define FADDR_MSB 6
`define IRQ_CTRL_ADDR 7'h0b
`define GIE_BIT 7
`define RESET_PC 13'h0000
`define RESET_W 8'h00
`endif

/* File: move_ret_pkg.sv */
// types for the move and return execution block
// assumes move_ret_cfg.svh is included by the users of the constants
package move_ret_pkg;
    typedef enum logic [2:0] {
        op_nop_type = 3'h0,
        op_store_type = 3'h1,
        op_loadlit_type = 3'h2,
        op_retlit_type = 3'h3,
        op_return_type = 3'h4,
        op_retirq_type = 3'h5,
        op_unknown_type = 3'h6
    } op_type;
    typedef enum logic [0:0] {
        st_exec = 1'b0,
        st_flush = 1'b1
    } state_type;
endpackage : move_ret_pkg

/* File: move_and_return_instruction_exec.sv */
// execution of store, load literal, no-op and the three return instructions
// assumes instructions come from fetch logic on clk_sys and the return stack
// shows its top entry combinationally on stack_top_entry
// Operation
// RULE1: store copies accumulator to file register 0..127, no flags, one cycle
// RULE2: load literal puts 8-bit immediate into accumulator, no flags, one cycle
// RULE3: return from irq pops stack, loads pc from top, sets global irq enable
// RULE4: return from irq is one word, two cycles, flags untouched
// RULE5: return with literal loads accumulator and pc from stack top, no flags; the code loads the accumulator from the 8-bit literal
// RULE6: return with literal is one word and two cycles
// RULE7: plain return pops stack into pc, two cycles, flags untouched
// RULE8: no-op is one word, one cycle, only advances the pc
`timescale 1ns/1ps
`include "move_ret_cfg.svh"
module move_and_return_instruction_exec #(
    parameter int INSTR_W = 14,
    parameter int PC_W = 13,
    parameter int DATA_W = 8,
    parameter int FADDR_W = 7
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic instr_valid,
    input wire logic [INSTR_W-1:0] instr_word,
    input wire logic [PC_W-1:0] stack_top_entry,
    input wire logic irq_entry,
    output logic instr_ready_q,
    output logic [PC_W-1:0] pc_q,
    output logic [DATA_W-1:0] w_q,
    output logic file_we_q,
    output logic [FADDR_W-1:0] file_addr_q,
    output logic [DATA_W-1:0] file_data_q,
    output logic stack_pop_q,
    output logic global_irq_enable_q,
    output logic unknown_op_q
);
    initial begin
        if (INSTR_W != 14 || DATA_W != 8 || FADDR_W != 7 || PC_W < 1 || PC_W > 16) begin
            $error("unsupported parameter set");
        end
    end

    function automatic move_ret_pkg::op_type decode(input logic [13:0] iw);
        move_ret_pkg::op_type r;
        r = move_ret_pkg::op_unknown_type;
        if ((iw & `OPC_STORE_MSK) == `OPC_STORE_VAL) begin
            r = move_ret_pkg::op_store_type;
        end else if ((iw & `OPC_LOADLIT_MSK) == `OPC_LOADLIT_VAL) begin
            r = move_ret_pkg::op_loadlit_type;
        end else if ((iw & `OPC_RETLIT_MSK) == `OPC_RETLIT_VAL) begin
            r = move_ret_pkg::op_retlit_type;
        end else if ((iw & `OPC_FULL_MSK) == `OPC_RETURN_VAL) begin
            r = move_ret_pkg::op_return_type;
        end else if ((iw & `OPC_FULL_MSK) == `OPC_RETIRQ_VAL) begin
            r = move_ret_pkg::op_retirq_type;
        end else if ((iw & `OPC_NOP_MSK) == `OPC_NOP_VAL) begin
            r = move_ret_pkg::op_nop_type;
        end
        return r;
    endfunction : decode

    move_ret_pkg::state_type state_q;
    move_ret_pkg::op_type op;
    logic take;
    logic [DATA_W-1:0] lit;
    logic [FADDR_W-1:0] faddr;
    logic is_return;

    assign take = instr_valid && instr_ready_q;
    assign op = decode(instr_word[13:0]);
    assign lit = instr_word[`LIT_MSB:0];
    assign faddr = instr_word[`FADDR_MSB:0];
    assign is_return = op == move_ret_pkg::op_retlit_type || op == move_ret_pkg::op_return_type
                       || op == move_ret_pkg::op_retirq_type;

    // returns spend a second cycle discarding the prefetched word
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= move_ret_pkg::st_exec;
            instr_ready_q <= 1'b0;
        end else begin
            unique case (state_q)
                move_ret_pkg::st_exec: begin
                    instr_ready_q <= !(take && is_return);
                    if (take && is_return) begin
                        state_q <= move_ret_pkg::st_flush; // RULE4 RULE6 RULE7
                    end
                end
                move_ret_pkg::st_flush: begin
                    state_q <= move_ret_pkg::st_exec;
                    instr_ready_q <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pc_q <= PC_W'(`RESET_PC);
        end else if (take) begin
            if (is_return) begin
                pc_q <= stack_top_entry; // RULE3 RULE5 RULE7
            end else begin
                pc_q <= pc_q + PC_W'(1); // RULE8
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stack_pop_q <= 1'b0;
        end else begin
            stack_pop_q <= take && is_return; // RULE3 RULE7
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            w_q <= `RESET_W;
        end else if (take && (op == move_ret_pkg::op_loadlit_type || op == move_ret_pkg::op_retlit_type)) begin
            w_q <= lit; // RULE2 RULE5
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            file_we_q <= 1'b0;
            file_addr_q <= '0;
            file_data_q <= '0;
        end else begin
            file_we_q <= take && op == move_ret_pkg::op_store_type; // RULE1
            if (take && op == move_ret_pkg::op_store_type) begin
                file_addr_q <= faddr; // RULE1
                file_data_q <= w_q; // RULE1
            end
        end
    end

    // return from irq wins over a simultaneous interrupt entry
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            global_irq_enable_q <= 1'b0;
        end else if (take && op == move_ret_pkg::op_retirq_type) begin
            global_irq_enable_q <= 1'b1; // RULE3
        end else if (take && op == move_ret_pkg::op_store_type && faddr == `IRQ_CTRL_ADDR) begin
            global_irq_enable_q <= w_q[`GIE_BIT];
        end else if (irq_entry) begin
            global_irq_enable_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            unknown_op_q <= 1'b0;
        end else begin
            unknown_op_q <= take && op == move_ret_pkg::op_unknown_type;
        end
    end

    a_store_writes: assert property (@(posedge clk_sys) disable iff (rst) // RULE1
        take && op == move_ret_pkg::op_store_type |=> file_we_q && file_data_q == $past(w_q)
            && file_addr_q == $past(faddr))
        else $error("store did not write accumulator");
    a_store_single: assert property (@(posedge clk_sys) disable iff (rst) // RULE1
        take && op == move_ret_pkg::op_store_type |=> instr_ready_q && !stack_pop_q)
        else $error("store took more than one cycle");
    a_load_literal: assert property (@(posedge clk_sys) disable iff (rst) // RULE2
        take && op == move_ret_pkg::op_loadlit_type |=> w_q == $past(lit) && pc_q == $past(pc_q) + PC_W'(1))
        else $error("literal not loaded");
    a_retirq_effect: assert property (@(posedge clk_sys) disable iff (rst) // RULE3
        take && op == move_ret_pkg::op_retirq_type |=> global_irq_enable_q && stack_pop_q
            && pc_q == $past(stack_top_entry))
        else $error("return from irq effect wrong");
    a_retirq_cycles: assert property (@(posedge clk_sys) disable iff (rst) // RULE4
        take && op == move_ret_pkg::op_retirq_type |=> !instr_ready_q ##1 instr_ready_q)
        else $error("return from irq not two cycles");
    a_retlit_effect: assert property (@(posedge clk_sys) disable iff (rst) // RULE5
        take && op == move_ret_pkg::op_retlit_type |=> w_q == $past(lit) && pc_q == $past(stack_top_entry))
        else $error("return with literal effect wrong");
    a_retlit_cycles: assert property (@(posedge clk_sys) disable iff (rst) // RULE6
        take && op == move_ret_pkg::op_retlit_type |=> !instr_ready_q ##1 instr_ready_q)
        else $error("return with literal not two cycles");
    a_return_pop: assert property (@(posedge clk_sys) disable iff (rst) // RULE7
        take && op == move_ret_pkg::op_return_type |=> stack_pop_q && pc_q == $past(stack_top_entry)
            && $stable(w_q) ##1 !stack_pop_q && instr_ready_q)
        else $error("plain return wrong");
    a_nop_quiet: assert property (@(posedge clk_sys) disable iff (rst) // RULE8
        take && op == move_ret_pkg::op_nop_type |=> pc_q == $past(pc_q) + PC_W'(1) && $stable(w_q)
            && !file_we_q && !stack_pop_q && instr_ready_q)
        else $error("no-op changed state");

    // a word offered while ready is low is refused and leaves no trace
    a_refuse_busy: assert property (@(posedge clk_sys) disable iff (rst) // RULE4 RULE6 RULE7
        !instr_ready_q |=> $stable(pc_q) && $stable(w_q) && !file_we_q && !stack_pop_q)
        else $error("word taken while not ready");

    // one-cycle words never pop and never drop ready
    a_single_no_pop: assert property (@(posedge clk_sys) disable iff (rst) // RULE1 RULE2 RULE8
        take && !is_return |=> instr_ready_q && !stack_pop_q)
        else $error("one-cycle word popped or stalled");

    // enable bit follows bit 7 of a word stored to the irq control address
    a_store_irq_ctrl: assert property (@(posedge clk_sys) disable iff (rst) // RULE3
        take && op == move_ret_pkg::op_store_type && faddr == `IRQ_CTRL_ADDR
            |=> global_irq_enable_q == $past(w_q[`GIE_BIT]))
        else $error("store to irq control did not load enable");

    // interrupt entry clears the enable unless a set or a load shares the edge
    a_irq_entry_clear: assert property (@(posedge clk_sys) disable iff (rst) // RULE3
        irq_entry && !(take && (op == move_ret_pkg::op_retirq_type || op == move_ret_pkg::op_store_type
            && faddr == `IRQ_CTRL_ADDR)) |=> !global_irq_enable_q)
        else $error("interrupt entry did not clear enable");

    // words outside the subset only advance the pc and raise the flag
    a_unknown_flag: assert property (@(posedge clk_sys) disable iff (rst)
        take && op == move_ret_pkg::op_unknown_type |=> unknown_op_q && pc_q == $past(pc_q) + PC_W'(1)
            && $stable(w_q) && !file_we_q && !stack_pop_q)
        else $error("unknown word not flagged");

    c_store: cover property (@(posedge clk_sys) disable iff (rst) take && op == move_ret_pkg::op_store_type);
    c_retirq: cover property (@(posedge clk_sys) disable iff (rst)
        take && op == move_ret_pkg::op_retirq_type && !global_irq_enable_q);
    c_retlit_b2b: cover property (@(posedge clk_sys) disable iff (rst)
        take && op == move_ret_pkg::op_retlit_type ##2 take && op == move_ret_pkg::op_retlit_type);
    c_irq_race: cover property (@(posedge clk_sys) disable iff (rst)
        take && op == move_ret_pkg::op_retirq_type && irq_entry);
    c_unknown: cover property (@(posedge clk_sys) disable iff (rst) take && op == move_ret_pkg::op_unknown_type);
endmodule : move_and_return_instruction_exec

/* File: tb_move_and_return_instruction_exec.sv */
// self-checking testbench for the move and return execution block
// assumes effects show just after the taking edge and ready drops for one cycle after a return
`timescale 1ns/1ps
module tb_move_and_return_instruction_exec;
    logic clk_sys;
    logic rst;
    logic instr_valid;
    logic irq_entry;
    logic [13:0] instr_word;
    logic [12:0] stack_top_entry;
    logic [12:0] pc_q;
    logic [12:0] exp_pc;
    logic [7:0] w_q;
    logic [7:0] file_data_q;
    logic [6:0] file_addr_q;
    logic instr_ready_q;
    logic file_we_q;
    logic stack_pop_q;
    logic global_irq_enable_q;
    logic unknown_op_q;
    int errors = 0;
    int check_count = 0;

    move_and_return_instruction_exec move_and_return_instruction_exec_inst (
        .clk_sys(clk_sys), .rst(rst), .instr_valid(instr_valid), .instr_word(instr_word),
        .stack_top_entry(stack_top_entry), .irq_entry(irq_entry), .instr_ready_q(instr_ready_q),
        .pc_q(pc_q), .w_q(w_q), .file_we_q(file_we_q), .file_addr_q(file_addr_q),
        .file_data_q(file_data_q), .stack_pop_q(stack_pop_q),
        .global_irq_enable_q(global_irq_enable_q), .unknown_op_q(unknown_op_q));

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task check(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            errors++;
            $display("ERROR %0t ns: %s", $time, msg);
        end
    endtask : check

    // present one word for one edge, then look just after the taking edge
    task send(input logic [13:0] w);
        @(posedge clk_sys);
        instr_valid <= 1'b1;
        instr_word <= w;
        @(posedge clk_sys);
        instr_valid <= 1'b0;
        #1;
        exp_pc = exp_pc + 13'h0001;
    endtask : send

    task one_cycle(input logic [13:0] w, input logic [7:0] w_exp, input logic we_exp);
        send(w);
        check(pc_q === exp_pc && w_q === w_exp && instr_ready_q === 1'b1, "one-cycle op pc or w wrong");
        check(file_we_q === we_exp && stack_pop_q === 1'b0 && unknown_op_q === 1'b0, "one-cycle op side effect wrong");
    endtask : one_cycle

    task t_store(input logic [6:0] a, input logic [7:0] w_exp);
        one_cycle({7'h01, a}, w_exp, 1'b1);
        check(file_addr_q === a && file_data_q === w_exp, "store address or data wrong");
        @(posedge clk_sys);
        #1;
        check(file_we_q === 1'b0 && pc_q === exp_pc, "store write not a single pulse");
    endtask : t_store

    // return: word held into the second cycle, where it must be refused
    task t_ret(input logic [13:0] w, input logic [12:0] top, input logic [7:0] w_exp, input logic g_exp);
        @(posedge clk_sys);
        instr_valid <= 1'b1;
        instr_word <= w;
        stack_top_entry <= top;
        @(posedge clk_sys);
        #1;
        check(pc_q === top && stack_pop_q === 1'b1 && instr_ready_q === 1'b0, "return first cycle wrong");
        check(w_q === w_exp && global_irq_enable_q === g_exp && file_we_q === 1'b0, "return w or enable wrong");
        @(posedge clk_sys);
        instr_valid <= 1'b0;
        #1;
        check(stack_pop_q === 1'b0 && instr_ready_q === 1'b1 && pc_q === top, "return second cycle wrong");
        exp_pc = top;
    endtask : t_ret

    task t_irq_clear;
        @(posedge clk_sys);
        irq_entry <= 1'b1;
        @(posedge clk_sys);
        irq_entry <= 1'b0;
        #1;
        check(global_irq_enable_q === 1'b0, "irq entry did not clear enable");
    endtask : t_irq_clear

    // interrupt entry on the edge that takes a return from irq: the set wins
    task t_retirq_race(input logic [12:0] top);
        @(posedge clk_sys);
        instr_valid <= 1'b1;
        instr_word <= 14'h0009;
        stack_top_entry <= top;
        irq_entry <= 1'b1;
        @(posedge clk_sys);
        irq_entry <= 1'b0;
        #1;
        check(global_irq_enable_q === 1'b1 && pc_q === top && stack_pop_q === 1'b1, "irq entry beat return from irq");
        @(posedge clk_sys);
        instr_valid <= 1'b0;
        exp_pc = top;
    endtask : t_retirq_race

    task t_unknown(input logic [13:0] w, input logic [7:0] w_exp);
        send(w);
        check(pc_q === exp_pc && w_q === w_exp && unknown_op_q === 1'b1, "unknown word not flagged");
        check(file_we_q === 1'b0 && stack_pop_q === 1'b0 && instr_ready_q === 1'b1, "unknown word side effect");
        @(posedge clk_sys);
        #1;
        check(unknown_op_q === 1'b0 && pc_q === exp_pc, "unknown flag not a single pulse");
    endtask : t_unknown

    // reset in mid-run: state cleared, ready only after the first edge
    task t_reset;
        @(posedge clk_sys);
        rst <= 1'b1;
        @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        check(pc_q === 13'h0000 && w_q === 8'h00 && global_irq_enable_q === 1'b0 && instr_ready_q === 1'b0,
            "reset did not clear state");
        @(posedge clk_sys);
        #1;
        check(instr_ready_q === 1'b1 && pc_q === 13'h0000, "not ready after reset");
        exp_pc = 13'h0000;
    endtask : t_reset

    task test_done;
        if (errors == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done

    initial begin
        #50000;
        errors++;
        test_done();
    end

    initial begin
        rst = 1'b1;
        instr_valid = 1'b0;
        irq_entry = 1'b0;
        instr_word = 14'h0000;
        stack_top_entry = 13'h0000;
        exp_pc = 13'h0000;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        #1;
        check(pc_q === 13'h0000 && w_q === 8'h00 && instr_ready_q === 1'b1, "state after reset wrong");
        one_cycle(14'h3000, 8'h00, 1'b0);
        one_cycle(14'h33a5, 8'ha5, 1'b0);
        t_store(7'h7f, 8'ha5);
        one_cycle(14'h0000, 8'ha5, 1'b0);
        t_ret(14'h0008, 13'h1abc, 8'ha5, 1'b0);
        t_ret(14'h0009, 13'h0123, 8'ha5, 1'b1);
        t_ret(14'h34ff, 13'h1fff, 8'hff, 1'b1);
        t_irq_clear();
        one_cycle(14'h0060, 8'hff, 1'b0);
        check(global_irq_enable_q === 1'b0, "no-op changed irq enable");
        t_store(7'h0b, 8'hff);
        check(global_irq_enable_q === 1'b1, "store to irq control did not load enable");
        one_cycle(14'h3000, 8'h00, 1'b0);
        t_store(7'h0b, 8'h00);
        check(global_irq_enable_q === 1'b0, "store to irq control did not clear enable");
        t_retirq_race(13'h0a5a);
        t_unknown(14'h3800, 8'h00);
        t_reset();
        one_cycle(14'h30c3, 8'hc3, 1'b0);
        test_done();
    end
endmodule : tb_move_and_return_instruction_exec
